// >>> verilog/switch_port_pkg.sv
package switch_port_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int PORTS = 4;
	localparam int PW = 2;
	localparam int MAC_W = 48;
	localparam int TBL_AW = 12;
	localparam int TBL_DEPTH = 4096;
	localparam int BUF_AW = 11;
	localparam int BUF_DEPTH = 2048;
	localparam logic [BUF_AW-1:0] BUF_LAST = 11'h7ff;
	localparam logic [BUF_AW-1:0] MIN_LAST = 11'h00d;
	localparam logic [TBL_AW-1:0] TBL_LAST = 12'hfff;
	localparam int MCAST_BIT = 40;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int NEG_TIME_NS = 20000;
	localparam int MDIX_TIME_NS = 10000;
	localparam int ACT_HOLD_NS = 30000;
	localparam logic [15:0] NEG_CYC = 16'((NEG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] MDIX_CYC = 16'((MDIX_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] ACT_CYC = 16'((ACT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PDV_100_HALF = 8'h32;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TBL_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_DROP_COUNT = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_FWD_COUNT = 8'h10;
	localparam int CFG_W = 3;
	localparam int STS_W = 4;
	localparam logic [PORTS*CFG_W-1:0] CFG_RESET = 12'h000;
	localparam logic [3:0] OWN_ABIL = 4'hf;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic sig;
		logic an;
		logic idle100;
		logic [3:0] abil; // 3:100F 2:100H 1:10F 0:10H
	} link_pins_t;

	typedef struct packed {
		logic xover_off;
		logic full;
		logic forced;
	} port_cfg_t;

	typedef struct packed {
		logic mdix;
		logic full;
		logic speed100;
		logic link;
	} port_sts_t;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [PW-1:0] port;
		logic [MAC_W-1:0] mac;
	} tbl_entry_t;

	typedef struct packed {
		logic sop;
		logic eop;
		logic err;
		logic [PW-1:0] port;
		logic [7:0] data;
	} rx_beat_t;

	typedef struct packed {
		logic sop;
		logic eop;
		logic [PORTS-1:0] mask;
		logic [7:0] data;
	} tx_beat_t;

	typedef enum {L_DOWN, L_NEG, L_UP} link_st_t;
	typedef enum {F_CLEAR, F_IDLE, F_CHECK, F_SEND} fwd_st_t;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// best common mode: {ok, speed100, full}
	function automatic logic [2:0] resolve(input logic [3:0] common);
		logic [2:0] r;
		r = 3'h0;
		if (common[3]) r = 3'h7;
		else if (common[2]) r = 3'h6;
		else if (common[1]) r = 3'h5;
		else if (common[0]) r = 3'h4;
		return r;
	endfunction

	function automatic logic [TBL_AW-1:0] tbl_hash(input logic [MAC_W-1:0] mac);
		return mac[11:0] ^ mac[23:12] ^ mac[35:24] ^ mac[47:36];
	endfunction

	function automatic logic [PORTS-1:0] port_bit(input logic [PW-1:0] p);
		return 4'h1 << p;
	endfunction

endpackage

// >>> verilog/switch_port_link_and_forwarding.sv
module switch_port_link_and_forwarding
	import switch_port_pkg::*;
#(
	parameter int unsigned AGE_STEP_CYC = 50000
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// link pins and indicators
	input wire link_pins_t [PORTS-1:0] link_pins_i,
	output logic [PORTS-1:0] mdix_o,
	output logic [PORTS-1:0] link_indicator_o,
	output logic [PORTS-1:0] activity_indicator_o,
	output logic [PORTS-1:0] duplex_indicator_o,
	output logic [PORTS-1:0] speed_indicator_o,
	output logic [PORTS-1:0][7:0] path_delay_value_o,
	// received frame stream
	input wire logic rx_valid_i,
	input wire rx_beat_t rx_beat_i,
	output logic rx_ready_o,
	// forwarded frame stream
	output logic tx_valid_o,
	output tx_beat_t tx_beat_o,
	input wire logic tx_ready_i
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	port_cfg_t [PORTS-1:0] cfg_ff;
	logic restart_ff;
	logic [31:0] rdata_ff;
	port_sts_t [PORTS-1:0] sts_all;
	logic [12:0] tbl_count_ff;
	logic [31:0] drop_count_ff;
	logic [31:0] fwd_count_ff;

	wire logic cfg_wr = reg_wr_i && reg_addr_i == REG_CFG;
	wire logic [31:0] rd_mux =
		(reg_addr_i == REG_CFG) ? 32'(cfg_ff) :
		(reg_addr_i == REG_STATUS) ? 32'(sts_all) :
		(reg_addr_i == REG_TBL_COUNT) ? 32'(tbl_count_ff) :
		(reg_addr_i == REG_DROP_COUNT) ? drop_count_ff :
		(reg_addr_i == REG_FWD_COUNT) ? fwd_count_ff : 32'h0000_0000;

	// config write; auto-negotiation is the reset mode
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_ff <= CFG_RESET;
			restart_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			if (cfg_wr)
				cfg_ff <= reg_wdata_i[PORTS*CFG_W-1:0];
			restart_ff <= cfg_wr;
			rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ------------------------------------------------------------
	// per-port link control
	// ------------------------------------------------------------
	logic tx_valid_ff;
	tx_beat_t tx_beat_ff;
	logic rx_ready_ff;

	for (genvar p = 0; p < PORTS; p++) begin : g_port
		link_pins_t s1_ff;
		link_pins_t s2_ff;
		link_st_t st_ff;
		logic [15:0] tmr_ff;
		logic [15:0] act_ff;
		logic act_led_ff;
		port_sts_t sts_ff;
		logic [7:0] pdv_ff;

		wire port_cfg_t cfg = cfg_ff[p];
		// crossover hunting is allowed unless forced with it switched off
		wire logic auto_x = !cfg.forced || !cfg.xover_off;
		wire logic [2:0] res = resolve(s2_ff.abil & OWN_ABIL);
		wire logic rx_hit = rx_valid_i && rx_ready_ff && rx_beat_i.port == PW'(p);
		wire logic tx_hit = tx_valid_ff && tx_ready_i && tx_beat_ff.mask[p];

		// pins are asynchronous to the switch clock
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				s1_ff <= '0;
				s2_ff <= '0;
			end else begin
				s1_ff <= link_pins_i[p];
				s2_ff <= s1_ff;
			end
		end

		// link state: every link-up passes through negotiation
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				st_ff <= L_DOWN;
				tmr_ff <= 16'h0000;
				sts_ff <= '0;
			end else begin
				case (st_ff)
					L_DOWN: begin
						sts_ff.link <= 1'b0;
						if (s2_ff.sig) begin
							st_ff <= L_NEG;
							tmr_ff <= 16'h0000;
							// a forced port with hunting off must not keep a crossed pair
							if (!auto_x)
								sts_ff.mdix <= 1'b0;
						end else if (auto_x) begin
							// flip pair assignment until energy appears
							if (tmr_ff == MDIX_CYC - 16'h0001) begin
								tmr_ff <= 16'h0000;
								sts_ff.mdix <= !sts_ff.mdix;
							end else begin
								tmr_ff <= tmr_ff + 16'h0001;
							end
						end else begin
							sts_ff.mdix <= 1'b0;
							tmr_ff <= 16'h0000;
						end
					end
					L_NEG: begin
						if (!s2_ff.sig || restart_ff) begin
							st_ff <= L_DOWN;
							tmr_ff <= 16'h0000;
						end else if (tmr_ff == NEG_CYC - 16'h0001) begin
							tmr_ff <= 16'h0000;
							if (cfg.forced) begin
								sts_ff.speed100 <= 1'b1;
								sts_ff.full <= cfg.full;
								sts_ff.link <= 1'b1;
								st_ff <= L_UP;
							end else if (s2_ff.an) begin
								if (res[2]) begin
									sts_ff.speed100 <= res[1];
									sts_ff.full <= res[0];
									sts_ff.link <= 1'b1;
									st_ff <= L_UP;
								end else begin
									st_ff <= L_DOWN;
								end
							end else begin
								sts_ff.speed100 <= s2_ff.idle100;
								sts_ff.full <= 1'b0;
								sts_ff.link <= 1'b1;
								st_ff <= L_UP;
							end
						end else begin
							tmr_ff <= tmr_ff + 16'h0001;
						end
					end
					L_UP: begin
						// a config change restarts the link so it takes effect
						if (!s2_ff.sig || restart_ff) begin
							st_ff <= L_DOWN;
							sts_ff.link <= 1'b0;
						end
					end
					default: begin
						st_ff <= L_DOWN;
					end
				endcase
			end
		end

		// activity stretch so single frames remain visible
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				act_ff <= 16'h0000;
				act_led_ff <= 1'b0;
				pdv_ff <= 8'h00;
			end else begin
				if (rx_hit || tx_hit)
					act_ff <= ACT_CYC;
				else if (act_ff != 16'h0000)
					act_ff <= act_ff - 16'h0001;
				act_led_ff <= rx_hit || tx_hit || act_ff != 16'h0000;
				pdv_ff <= (sts_ff.link && sts_ff.speed100 && !sts_ff.full) ? PDV_100_HALF : 8'h00;
			end
		end

		assign sts_all[p] = sts_ff;
		assign mdix_o[p] = sts_ff.mdix;
		assign link_indicator_o[p] = sts_ff.link;
		assign duplex_indicator_o[p] = sts_ff.full;
		assign speed_indicator_o[p] = sts_ff.speed100;
		assign activity_indicator_o[p] = act_led_ff;
		assign path_delay_value_o[p] = pdv_ff;
	end

	// ------------------------------------------------------------
	// frame store and station table
	// ------------------------------------------------------------
	logic [7:0] buf_mem [BUF_DEPTH];
	tbl_entry_t tbl_mem [TBL_DEPTH];

	fwd_st_t st_ff;
	fwd_st_t nxt_st;
	logic [BUF_AW-1:0] wr_ptr_ff;
	logic [BUF_AW-1:0] rd_ptr_ff;
	logic [BUF_AW-1:0] last_ff;
	logic in_frame_ff;
	logic bad_ff;
	logic sent_eop_ff;
	logic [MAC_W-1:0] da_ff;
	logic [MAC_W-1:0] sa_ff;
	logic [PW-1:0] src_ff;
	logic [TBL_AW-1:0] idx_ff;
	logic [31:0] age_cnt_ff;
	logic age_due_ff;

	// receive side decode
	wire logic rx_take = rx_valid_i && rx_ready_ff;
	wire logic [BUF_AW-1:0] pos = rx_beat_i.sop ? '0 : wr_ptr_ff;
	wire logic rx_live = rx_take && (rx_beat_i.sop || in_frame_ff);
	wire logic rx_end = rx_live && rx_beat_i.eop;
	wire logic overflow = rx_live && !rx_beat_i.eop && pos == BUF_LAST;

	// lookup decode
	wire logic [TBL_AW-1:0] da_idx = tbl_hash(da_ff);
	wire logic [TBL_AW-1:0] sa_idx = tbl_hash(sa_ff);
	wire tbl_entry_t da_ent = tbl_mem[da_idx];
	wire tbl_entry_t sa_ent = tbl_mem[sa_idx];
	wire tbl_entry_t ag_ent = tbl_mem[idx_ff];
	wire logic da_mcast = da_ff[MCAST_BIT];
	wire logic da_known = da_ent.valid && da_ent.mac == da_ff;
	wire logic [PORTS-1:0] others = ~port_bit(src_ff);
	wire logic filter = !da_mcast && da_known && da_ent.port == src_ff;
	wire logic [PORTS-1:0] fwd_mask =
		da_mcast ? others :
		da_known ? port_bit(da_ent.port) : others;
	wire logic checking = st_ff == F_CHECK;
	wire logic learn_en = checking && !bad_ff && !sa_ff[MCAST_BIT];
	wire logic age_en = st_ff == F_IDLE && age_due_ff;
	wire logic clr_en = st_ff == F_CLEAR;

	// one write port to the table: clear, learn or age
	wire logic tw_en = clr_en || learn_en || age_en;
	wire logic [TBL_AW-1:0] tw_addr = learn_en ? sa_idx : idx_ff;
	wire tbl_entry_t learn_ent = '{valid: 1'b1, hit: 1'b1, port: src_ff, mac: sa_ff};
	wire tbl_entry_t aged_ent = '{valid: ag_ent.valid && ag_ent.hit, hit: 1'b0, port: ag_ent.port, mac: ag_ent.mac};
	wire tbl_entry_t tw_data = clr_en ? '0 : learn_en ? learn_ent : aged_ent;
	wire logic count_up = learn_en && !sa_ent.valid;
	wire logic count_dn = age_en && ag_ent.valid && !ag_ent.hit;

	// transmit handshake
	wire logic tx_fire = tx_valid_ff && tx_ready_i;
	wire logic tx_load = st_ff == F_SEND && !sent_eop_ff && (!tx_valid_ff || tx_ready_i);
	wire logic tx_done = tx_fire && tx_beat_ff.eop;

	// next state of the forwarding engine
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			F_CLEAR: begin
				if (idx_ff == TBL_LAST)
					nxt_st = F_IDLE;
			end
			F_IDLE: begin
				if (rx_end)
					nxt_st = F_CHECK;
			end
			F_CHECK: begin
				nxt_st = (bad_ff || filter) ? F_IDLE : F_SEND;
			end
			F_SEND: begin
				if (tx_done)
					nxt_st = F_IDLE;
			end
			default: begin
				nxt_st = F_IDLE;
			end
		endcase
	end

	// storage arrays carry no reset; the clear walk empties the table
	always_ff @(posedge sys_clk_i) begin
		if (rx_live)
			buf_mem[pos] <= rx_beat_i.data;
		if (tw_en)
			tbl_mem[tw_addr] <= tw_data;
	end

	// receive capture and header fields
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			last_ff <= '0;
			in_frame_ff <= 1'b0;
			bad_ff <= 1'b0;
			da_ff <= '0;
			sa_ff <= '0;
			src_ff <= '0;
		end else if (rx_live) begin
			in_frame_ff <= !rx_beat_i.eop;
			if (!overflow)
				wr_ptr_ff <= pos + 11'h001;
			if (rx_beat_i.sop) begin
				src_ff <= rx_beat_i.port;
				// a one-byte frame is a runt as well
				bad_ff <= rx_beat_i.err || rx_beat_i.eop;
			end else begin
				// errored, oversize or runt frames never leave the store
				bad_ff <= bad_ff || rx_beat_i.err || overflow || (rx_beat_i.eop && pos < MIN_LAST);
			end
			if (pos < 11'h006)
				da_ff <= {da_ff[MAC_W-9:0], rx_beat_i.data};
			else if (pos < 11'h00c)
				sa_ff <= {sa_ff[MAC_W-9:0], rx_beat_i.data};
			if (rx_beat_i.eop)
				last_ff <= pos;
		end
	end

	// engine state, table walk and aging tick
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= F_CLEAR;
			idx_ff <= '0;
			age_cnt_ff <= 32'h0000_0000;
			age_due_ff <= 1'b0;
			rx_ready_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			rx_ready_ff <= nxt_st == F_IDLE;
			if (clr_en || age_en)
				idx_ff <= idx_ff + 12'h001;
			if (age_cnt_ff == 32'(AGE_STEP_CYC) - 32'h0000_0001) begin
				age_cnt_ff <= 32'h0000_0000;
				age_due_ff <= 1'b1;
			end else begin
				age_cnt_ff <= age_cnt_ff + 32'h0000_0001;
				if (age_en)
					age_due_ff <= 1'b0;
			end
		end
	end

	// statistics
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tbl_count_ff <= 13'h0000;
			drop_count_ff <= 32'h0000_0000;
			fwd_count_ff <= 32'h0000_0000;
		end else begin
			if (count_up)
				tbl_count_ff <= tbl_count_ff + 13'h0001;
			else if (count_dn)
				tbl_count_ff <= tbl_count_ff - 13'h0001;
			if (checking && (bad_ff || filter))
				drop_count_ff <= drop_count_ff + 32'h0000_0001;
			if (checking && !bad_ff && !filter)
				fwd_count_ff <= fwd_count_ff + 32'h0000_0001;
		end
	end

	// forwarded stream out of the store
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr_ff <= '0;
			sent_eop_ff <= 1'b0;
			tx_valid_ff <= 1'b0;
			tx_beat_ff <= '0;
		end else begin
			if (checking) begin
				rd_ptr_ff <= '0;
				sent_eop_ff <= 1'b0;
				tx_beat_ff.mask <= fwd_mask;
			end
			if (tx_load) begin
				tx_valid_ff <= 1'b1;
				tx_beat_ff.data <= buf_mem[rd_ptr_ff];
				tx_beat_ff.sop <= rd_ptr_ff == '0;
				tx_beat_ff.eop <= rd_ptr_ff == last_ff;
				sent_eop_ff <= rd_ptr_ff == last_ff;
				rd_ptr_ff <= rd_ptr_ff + 11'h001;
			end else if (tx_fire) begin
				tx_valid_ff <= 1'b0;
			end
		end
	end

	assign rx_ready_o = rx_ready_ff;
	assign tx_valid_o = tx_valid_ff;
	assign tx_beat_o = tx_beat_ff;

endmodule

// >>> dv/switch_port_link_and_forwarding_monitor.sv
module switch_port_link_and_forwarding_monitor
	import switch_port_pkg::*;
#(
	parameter int unsigned AGE_STEP_CYC = 50000
) (
	// clock, reset, register port
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// link pins and indicators
	input wire link_pins_t [PORTS-1:0] link_pins_i,
	input wire logic [PORTS-1:0] mdix_o,
	input wire logic [PORTS-1:0] link_indicator_o,
	input wire logic [PORTS-1:0] activity_indicator_o,
	input wire logic [PORTS-1:0] duplex_indicator_o,
	input wire logic [PORTS-1:0] speed_indicator_o,
	input wire logic [PORTS-1:0][7:0] path_delay_value_o,
	// frame streams
	input wire logic rx_valid_i,
	input wire rx_beat_t rx_beat_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire tx_beat_t tx_beat_o,
	input wire logic tx_ready_i
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// frame path
	// ------------------------------------------------------------
	sequence tx_stall;
		tx_valid_o && !tx_ready_i;
	endsequence
	sequence rx_last;
		rx_valid_i && rx_ready_o && rx_beat_i.eop;
	endsequence
	// cycles since reset, saturating; the clear walk takes the whole table
	logic [12:0] clr_cnt_ff;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clr_cnt_ff <= '0;
		end else if (!clr_cnt_ff[12]) begin
			clr_cnt_ff <= clr_cnt_ff + 13'h1;
		end
	end
	chk_clear_first: assert property (rx_ready_o |-> clr_cnt_ff >= 13'hfff)
		else $error("frames accepted before table clear");
	chk_store_first: assert property (rx_ready_o |-> !tx_valid_o)
		else $error("forwarding while still receiving");
	chk_frame_closes: assert property (rx_last |=> !rx_ready_o)
		else $error("intake open after last byte");
	chk_tx_holds: assert property (tx_stall |=> tx_valid_o && $stable(tx_beat_o))
		else $error("forwarded beat changed while stalled");
	chk_mask_fixed: assert property (tx_valid_o && !tx_beat_o.sop |-> tx_beat_o.mask == $past(tx_beat_o.mask))
		else $error("port mask changed within a frame");

	// ------------------------------------------------------------
	// per port link
	// ------------------------------------------------------------
	for (genvar g = 0; g < PORTS; g++) begin : gp
		// steady line signal; a link may not come up before negotiation time
		logic [11:0] sig_cnt_ff;
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				sig_cnt_ff <= '0;
			end else begin
				sig_cnt_ff <= !link_pins_i[g].sig ? 12'h0 : sig_cnt_ff + {11'h0, ~&sig_cnt_ff};
			end
		end
		chk_link_waits: assert property ($rose(link_indicator_o[g]) |-> sig_cnt_ff >= NEG_CYC)
			else $error("link up without negotiation time");
		chk_link_drops: assert property (!link_pins_i[g].sig [*6] |-> !link_indicator_o[g])
			else $error("link shown without line signal");
		chk_pdv_follows: assert property (path_delay_value_o[g] == ($past(link_indicator_o[g]
			& speed_indicator_o[g] & ~duplex_indicator_o[g]) ? 8'h32 : 8'h00))
			else $error("path delay value wrong");
		chk_act_lights: assert property (rx_valid_i && rx_ready_o && rx_beat_i.port == PW'(g)
			|-> ##[1:3] activity_indicator_o[g])
			else $error("activity not shown");
	end
endmodule

bind switch_port_link_and_forwarding switch_port_link_and_forwarding_monitor #(
	.AGE_STEP_CYC(AGE_STEP_CYC)
) u_switch_port_link_and_forwarding_monitor (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link_pins_i(link_pins_i),
	.mdix_o(mdix_o), .link_indicator_o(link_indicator_o), .activity_indicator_o(activity_indicator_o),
	.duplex_indicator_o(duplex_indicator_o), .speed_indicator_o(speed_indicator_o),
	.path_delay_value_o(path_delay_value_o), .rx_valid_i(rx_valid_i), .rx_beat_i(rx_beat_i),
	.rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_beat_o(tx_beat_o), .tx_ready_i(tx_ready_i)
);

// >>> dv/link_station.sv
module link_station
	import switch_port_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// wanted line state per port
	input wire link_pins_t [PORTS-1:0] want_i,
	output link_pins_t [PORTS-1:0] link_pins_o,
	// forwarded stream sink
	input wire logic tx_valid_i,
	input wire tx_beat_t tx_beat_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got[$];
	logic [PORTS-1:0] got_mask;

	// station power, abilities and idle speed; ready stalls every other cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_pins_o <= '0;
			tx_ready_o <= 1'b0;
		end else begin
			link_pins_o <= want_i;
			tx_ready_o <= ~tx_ready_o;
		end
	end
	// collect every byte taken
	always @(posedge sys_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_beat_i.data);
			got_mask = tx_beat_i.mask;
		end
	end
endmodule

// >>> dv/switch_port_link_and_forwarding_test.sv
module switch_port_link_and_forwarding_test
	import switch_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [47:0] STA_A = 48'h02000000000a;
	localparam logic [47:0] STA_B = 48'h02000000000b;
	localparam logic [47:0] STA_C = 48'h02000000000c;
	localparam logic [47:0] STA_D = 48'h02000000000d;
	localparam logic [47:0] BCAST = 48'hffffffffffff;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rx_valid = 1'b0;
	rx_beat_t rx_beat = '0;
	link_pins_t [PORTS-1:0] want = '0;
	logic [31:0] reg_rdata, rd;
	link_pins_t [PORTS-1:0] link_pins;
	logic [PORTS-1:0] mdix, link_ind, act_ind, dup_ind, spd_ind;
	logic [PORTS-1:0][7:0] path_delay_value;
	logic rx_ready, tx_valid, tx_ready, m;
	tx_beat_t tx_beat;
	int miscompares = 0;
	int cmp_count = 0;

	always #5 sys_clk = ~sys_clk;

	// short aging step would empty the table mid-run, so keep it long
	switch_port_link_and_forwarding #(.AGE_STEP_CYC(100000)) u_switch_port_link_and_forwarding (
		.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .link_pins_i(link_pins),
		.mdix_o(mdix), .link_indicator_o(link_ind), .activity_indicator_o(act_ind),
		.duplex_indicator_o(dup_ind), .speed_indicator_o(spd_ind), .path_delay_value_o(path_delay_value),
		.rx_valid_i(rx_valid), .rx_beat_i(rx_beat), .rx_ready_o(rx_ready),
		.tx_valid_o(tx_valid), .tx_beat_o(tx_beat), .tx_ready_i(tx_ready));
	link_station u_link_station (.sys_clk_i(sys_clk), .rst_i(rst), .want_i(want), .link_pins_o(link_pins),
		.tx_valid_i(tx_valid), .tx_beat_i(tx_beat), .tx_ready_o(tx_ready));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		while (!rx_ready && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		check("rx ready", rx_ready, 1'b1);
	endtask
	// send one frame and compare what leaves; mask 0 means dropped
	task automatic run_frame(input logic [1:0] p, input logic [47:0] da, input logic [47:0] sa,
			input int len, input logic err, input logic [3:0] mask);
		logic [7:0] sent[$];
		u_link_station.got.delete();
		for (int i = 0; i < len; i++) begin
			sent.push_back(i < 6 ? da[47 - 8 * i -: 8] : i < 12 ? sa[95 - 8 * i -: 8] : 8'(i));
			rx_valid <= 1'b1;
			rx_beat <= '{i == 0, i == len - 1, err, p, sent[i]};
			@(posedge sys_clk);
			while (!rx_ready) @(posedge sys_clk);
		end
		rx_valid <= 1'b0;
		// ready still reads high in the edge that took the last byte
		@(posedge sys_clk);
		wait_ready();
		check("tx bytes", u_link_station.got.size(), mask != 4'h0 ? len : 0);
		check("tx mask", mask != 4'h0 ? u_link_station.got_mask : 4'h0, mask);
		foreach (sent[i]) if (mask != 4'h0) check("tx byte", u_link_station.got[i], sent[i]);
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wait_ready();
		reg_read(REG_CFG, rd);
		check("cfg reset", rd, 32'h0);
		// {sig, an, idle100, abil}, port 3 first: silent 10, silent 100, all, 10 only
		want <= {7'h40, 7'h50, 7'h6f, 7'h63};
		repeat (2020) @(posedge sys_clk);
		reg_read(REG_STATUS, rd);
		check("status", rd & 32'h7777, 32'h1375);
		check("leds", {link_ind, spd_ind, dup_ind}, 32'hf63);
		check("pdv", path_delay_value, 32'h00320000);
		run_frame(2'h0, BCAST, STA_A, 16, 1'b0, 4'he);
		run_frame(2'h1, STA_A, STA_B, 20, 1'b0, 4'h1);
		run_frame(2'h2, STA_B, STA_C, 14, 1'b0, 4'h2);
		run_frame(2'h0, STA_A, STA_D, 16, 1'b0, 4'h0);
		run_frame(2'h3, STA_B, STA_D, 16, 1'b1, 4'h0);
		run_frame(2'h3, STA_B, STA_D, 13, 1'b0, 4'h0);
		run_frame(2'h3, STA_C, STA_A, 16, 1'b0, 4'h4);
		run_frame(2'h1, STA_A, STA_B, 16, 1'b0, 4'h8);
		check("activity", act_ind[1], 1'b1);
		reg_read(REG_FWD_COUNT, rd);
		check("fwd count", rd, 32'h5);
		reg_read(REG_DROP_COUNT, rd);
		check("drop count", rd, 32'h3);
		reg_read(REG_TBL_COUNT, rd);
		check("table count", rd, 32'h4);
		reg_write(REG_STATUS, 32'h0);
		reg_write(8'h14, 32'hffffffff);
		reg_read(8'h14, rd);
		check("unmapped", rd, 32'h0);
		reg_read(REG_STATUS, rd);
		check("status kept", rd & 32'h7777, 32'h1375);
		// port 3 forced, full duplex, crossover hunt off
		reg_write(REG_CFG, 32'he00);
		reg_read(REG_CFG, rd);
		check("cfg", rd, 32'he00);
		repeat (2020) @(posedge sys_clk);
		reg_read(REG_STATUS, rd);
		check("forced", rd & 32'h7777, 32'h7375);
		check("no hunt", mdix[3], 1'b0);
		want[0].sig <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check("link lost", link_ind, 32'he);
		m = mdix[0];
		repeat (1000) @(posedge sys_clk);
		check("mdix hunt", mdix[0] ^ m, 1'b1);
		want[0].sig <= 1'b1;
		repeat (2020) @(posedge sys_clk);
		check("link again", link_ind, 32'hf);
		stop_test();
	end

	// hang guard, well past the expected run length
	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		stop_test();
	end
endmodule
